// >>> src/vcm_map.svh
// How it works
// - Air saving on and over six valve switches in three seconds: drop saving, hold suction.
// - Valve protection trip raises a warning and sets warning bit 0.
// - Lower-to-upper time over the limit sets bit 1 and turns status yellow.
// - Evacuation limit up to 9.99 s, zero means off, at index 0x006B.
// - Time from cycle start to lower point, in ms, readable at 0x0094.
// - Time from lower to upper point, in ms, readable at 0x0095.
// - Control mode: after saving stops suction, measure vacuum drop in mbar/s.
// - Leakage under limit: let vacuum fall to resume point, then suck again.
// - Leakage over limit: set bit 2, alternate display limit and vacuum.
// - Upper point never reached: bit 3 at end of suction phase, held.
// - Dynamic pressure above lower minus hysteresis and below upper sets bit 4.
// - Supply out of range: device status, bit 5 or 6, and a link event.
// - Undervoltage: stop valves; open falls to suction, closed to off, impulse holds.
// - Undervoltage during manual operation ends manual operation.
// - Overvoltage also raises a condition event.
// - Any event in a cycle turns status yellow; cause in word at 0x0092.
// - Bit 7 system pressure low in suction, bit 8 preset pressure out of range.
// - Bits 0 to 3 clear at cycle start and hold until the next cycle start.
// - Bit 4 clears at power-up and changes only on a new dynamic value.
// - Bits 5 to 8 follow present supply and pressure continuously.
// - Both times and leakage clear at cycle start, update once measured.
`ifndef VCM_MAP_SVH
`define VCM_MAP_SVH
`define VCM_IDX_EVAC_LIMIT   16'h006B
`define VCM_IDX_WARN         16'h0092
`define VCM_IDX_EVAC_FIRST   16'h0094
`define VCM_IDX_EVAC_SECOND  16'h0095
`define VCM_IDX_LEAK         16'h0096
`define VCM_IDX_DEVSTAT      16'h0097
`define VCM_EVAC_LIMIT_MAX   16'd999
`define VCM_EVAC_LIMIT_OFF   16'd0
`define VCM_EVAC_LIMIT_RST   16'd0
`define VCM_MS_PER_LIMIT_LSB 16'd10
`define VCM_CLK_MHZ          100
`define VCM_MS_NS            1000000
`define VCM_CLK_NS           10
`define VCM_MS_CYCLES        (`VCM_MS_NS / `VCM_CLK_NS)
`define VCM_WIN_MS           3000
`define VCM_WIN_SLOTS        30
`define VCM_SLOT_MS          100
`define VCM_SWITCH_MAX       6
`define VCM_LEAK_MS          1000
`define VCM_DYN_MS           1000
`define VCM_DYN_MIN_MBAR     16'd5
`define VCM_BLINK_MS         500
`define VCM_BIT_VALVE        0
`define VCM_BIT_EVAC         1
`define VCM_BIT_LEAK         2
`define VCM_BIT_UPPER        3
`define VCM_BIT_DYN          4
`define VCM_BIT_SUP_SENS     5
`define VCM_BIT_SUP_ACT      6
`define VCM_BIT_PRESS_LOW    7
`define VCM_BIT_PRESS_RANGE  8
`endif

// >>> src/vcm_pkg.sv
package vcm_pkg;
  typedef enum logic [1:0] {VCM_VAR_OPEN, VCM_VAR_CLOSED, VCM_VAR_IMPULSE} vcm_variant_type;

  typedef struct packed {
    logic [15:0] upper_switch_point;
    logic [15:0] lower_switch_point;
    logic [15:0] lower_hysteresis;
    logic [15:0] resume_point;
    logic [15:0] leak_limit;
  } vcm_limits_type;

  typedef struct packed {
    logic sens_under;
    logic sens_over;
    logic act_under;
    logic act_over;
    logic press_low;
    logic press_range;
  } vcm_supply_type;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] index;
    logic [15:0] wdata;
  } vcm_param_req_type;
endpackage

// >>> src/vcm_ms_tick.sv
`timescale 1ns/100ps
`default_nettype none
`include "vcm_map.svh"
module vcm_ms_tick #(
  parameter int CYCLES = `VCM_MS_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  output logic      tick
);
  logic [31:0] count;
  logic [31:0] next_count;

  always_comb begin
    next_count = (count == 32'(CYCLES - 1)) ? 32'h0 : count + 32'h1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 32'h0;
    end else begin
      count <= next_count;
    end
  end

  assign tick = (count == 32'(CYCLES - 1));
endmodule // vcm_ms_tick
`default_nettype wire

// >>> src/vcm_switch_window.sv
`timescale 1ns/100ps
`default_nettype none
`include "vcm_map.svh"
module vcm_switch_window #(
  parameter int SLOTS   = `VCM_WIN_SLOTS,
  parameter int SLOT_MS = `VCM_SLOT_MS
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       ms_tick,
  input  wire logic       switch_pulse,
  output logic      [7:0] total
);
  // Slot ring trades exactness of the window edge for area: 100 ms granularity
  logic [3:0]  slot [SLOTS];
  logic [3:0]  next_slot [SLOTS];
  logic [7:0]  ms_count;
  logic [7:0]  next_ms_count;
  logic [4:0]  head;
  logic [4:0]  next_head;
  logic        advance;

  always_comb begin
    advance       = ms_tick && (ms_count == 8'(SLOT_MS - 1));
    next_ms_count = ms_tick ? (advance ? 8'h0 : ms_count + 8'h1) : ms_count;
    next_head     = advance ? ((head == 5'(SLOTS - 1)) ? 5'h0 : head + 5'h1) : head;
    total         = 8'h0;
    for (int i = 0; i < SLOTS; i++) begin
      next_slot[i] = slot[i];
      total        = total + 8'(slot[i]);
    end
    if (advance) begin
      next_slot[next_head] = 4'(switch_pulse);
    end else if (switch_pulse && slot[head] != 4'hF) begin
      next_slot[head] = slot[head] + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_count <= 8'h0;
      head     <= 5'h0;
      for (int i = 0; i < SLOTS; i++) begin
        slot[i] <= 4'h0;
      end
    end else begin
      ms_count <= next_ms_count;
      head     <= next_head;
      for (int i = 0; i < SLOTS; i++) begin
        slot[i] <= next_slot[i];
      end
    end
  end
endmodule // vcm_switch_window
`default_nettype wire

// >>> src/vcm_condition_watch.sv
`timescale 1ns/100ps
`default_nettype none
`include "vcm_map.svh"
module vcm_condition_watch #(
  parameter int MS_CYCLES = `VCM_MS_CYCLES,
  parameter int LEAK_MS   = `VCM_LEAK_MS,
  parameter int DYN_MS    = `VCM_DYN_MS,
  parameter int BLINK_MS  = `VCM_BLINK_MS
) (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire vcm_pkg::vcm_param_req_type param_req,
  output logic                    [15:0] param_rdata,
  output logic                           param_ack,
  input  wire logic                      suction_cmd,
  input  wire logic                      air_saving_en,
  input  wire logic                      control_mode,
  input  wire logic                      manual_req,
  input  wire vcm_pkg::vcm_variant_type  variant,
  input  wire logic               [15:0] vacuum,
  input  wire vcm_pkg::vcm_limits_type   limits,
  input  wire vcm_pkg::vcm_supply_type   supply,
  output logic                           suction_valve,
  output logic                           valve_drive_en,
  output logic                           manual_active,
  output logic                           air_saving_dis,
  output logic                           status_yellow,
  output logic                           show_leak_limit,
  output logic                           link_event,
  output logic                    [15:0] leak_rate
);
  import vcm_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_EVAC, ST_HOLD, ST_LEAK, ST_DECAY} vcm_state_type;

  logic          ms_tick;
  logic    [7:0] switch_total;
  vcm_state_type state, next_state;
  logic   [15:0] evac_limit, next_evac_limit;
  logic    [8:0] warn, next_warn;
  logic   [15:0] evac_first, next_evac_first;
  logic   [15:0] evac_second, next_evac_second;
  logic   [15:0] next_leak_rate;
  logic   [15:0] phase_ms, next_phase_ms;
  logic   [15:0] leak_start, next_leak_start;
  logic          lower_seen, next_lower_seen;
  logic          upper_seen, next_upper_seen;
  logic          saving_dis, next_saving_dis;
  logic          valve, next_valve;
  logic          manual, next_manual;
  logic          suction_prev, next_suction_prev;
  logic          supply_bad_prev, next_supply_bad_prev;
  logic          event_q, next_event_q;
  logic   [15:0] blink_ms, next_blink_ms;
  logic          blink, next_blink;
  logic   [15:0] rdata, next_rdata;
  logic          ack, next_ack;
  logic          under_v, over_v, cycle_start, cycle_end, supply_bad;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h1;
  endfunction

  vcm_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (ms_tick)
  );

  vcm_switch_window u_window (
    .clk          (clk),
    .reset_n      (reset_n),
    .ms_tick      (ms_tick),
    .switch_pulse (valve != next_valve),
    .total        (switch_total)
  );

  always_comb begin
    under_v     = supply.sens_under || supply.act_under;
    over_v      = supply.sens_over || supply.act_over;
    supply_bad  = under_v || over_v;
    cycle_start = suction_cmd && !suction_prev;
    cycle_end   = !suction_cmd && suction_prev;

    next_state           = state;
    next_warn            = warn;
    next_evac_first      = evac_first;
    next_evac_second     = evac_second;
    next_leak_rate       = leak_rate;
    next_phase_ms        = ms_tick ? sat_inc(phase_ms) : phase_ms;
    next_leak_start      = leak_start;
    next_lower_seen      = lower_seen;
    next_upper_seen      = upper_seen;
    next_saving_dis      = saving_dis;
    next_valve           = valve;
    next_manual          = manual_req;
    next_suction_prev    = suction_cmd;
    next_supply_bad_prev = supply_bad;
    next_event_q         = 1'b0;
    next_evac_limit      = evac_limit;
    next_ack             = param_req.req;
    next_rdata           = rdata;

    // Parameter access
    if (param_req.req && param_req.wr && param_req.index == `VCM_IDX_EVAC_LIMIT) begin
      if (param_req.wdata <= `VCM_EVAC_LIMIT_MAX) begin
        next_evac_limit = param_req.wdata;
      end
    end
    if (param_req.req && !param_req.wr) begin
      unique case (param_req.index)
        `VCM_IDX_EVAC_LIMIT:  next_rdata = evac_limit;
        `VCM_IDX_WARN:        next_rdata = {7'h0, warn};
        `VCM_IDX_EVAC_FIRST:  next_rdata = evac_first;
        `VCM_IDX_EVAC_SECOND: next_rdata = evac_second;
        `VCM_IDX_LEAK:        next_rdata = leak_rate;
        `VCM_IDX_DEVSTAT:     next_rdata = {15'h0, supply_bad};
        default:              next_rdata = 16'h0;
      endcase
    end

    // Suction cycle sequencing
    if (cycle_start) begin
      next_warn[3:0]   = 4'h0;
      next_evac_first  = 16'h0;
      next_evac_second = 16'h0;
      next_leak_rate   = 16'h0;
      next_phase_ms    = 16'h0;
      next_lower_seen  = 1'b0;
      next_upper_seen  = 1'b0;
      next_saving_dis  = 1'b0;
      next_valve       = 1'b1;
      next_state       = ST_EVAC;
    end else if (cycle_end) begin
      if (!upper_seen) begin
        next_warn[`VCM_BIT_UPPER] = 1'b1;
      end
      next_valve = 1'b0;
      next_state = ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: next_valve = 1'b0;
        ST_EVAC: begin
          if (!lower_seen && vacuum >= limits.lower_switch_point) begin
            next_lower_seen = 1'b1;
            next_evac_first = phase_ms;
            next_phase_ms   = 16'h0;
          end
          if (lower_seen && !upper_seen && vacuum >= limits.upper_switch_point) begin
            next_upper_seen  = 1'b1;
            next_evac_second = phase_ms;
            if (evac_limit != `VCM_EVAC_LIMIT_OFF &&
                phase_ms > 16'(evac_limit * `VCM_MS_PER_LIMIT_LSB)) begin
              next_warn[`VCM_BIT_EVAC] = 1'b1;
            end
          end
          if (lower_seen && phase_ms == 16'(DYN_MS) && ms_tick) begin
            // Only a clean, open-nozzle reading replaces the old value
            if (vacuum >= `VCM_DYN_MIN_MBAR && vacuum < limits.upper_switch_point) begin
              next_warn[`VCM_BIT_DYN] = (vacuum > limits.lower_switch_point - limits.lower_hysteresis);
            end
          end
          if (vacuum >= limits.upper_switch_point && air_saving_en && !saving_dis) begin
            // Upper point counts as reached even when lower and upper pass in one sample
            next_upper_seen = 1'b1;
            next_valve      = 1'b0;
            next_leak_start = vacuum;
            next_phase_ms   = 16'h0;
            next_state      = control_mode ? ST_LEAK : ST_HOLD;
          end
        end
        ST_HOLD: if (vacuum < limits.resume_point) begin
          next_valve = 1'b1;
          next_state = ST_EVAC;
        end
        ST_LEAK: if (ms_tick && phase_ms == 16'(LEAK_MS - 1)) begin
          next_leak_rate = (vacuum < leak_start) ? leak_start - vacuum : 16'h0;
          if ((leak_start > vacuum) && (leak_start - vacuum > limits.leak_limit)) begin
            next_warn[`VCM_BIT_LEAK] = 1'b1;
          end
          next_state = ST_DECAY;
        end else if (vacuum < limits.resume_point) begin
          next_valve = 1'b1;
          next_state = ST_EVAC;
        end
        ST_DECAY: if (vacuum < limits.resume_point) begin
          next_valve = 1'b1;
          next_state = ST_EVAC;
        end
      endcase
    end

    // Valve protection
    if (suction_cmd && air_saving_en && !saving_dis && switch_total > 8'(`VCM_SWITCH_MAX)) begin
      next_saving_dis            = 1'b1;
      next_valve                 = 1'b1;
      next_state                 = ST_EVAC;
      next_warn[`VCM_BIT_VALVE]  = 1'b1;
    end

    // Continuous bits
    next_warn[`VCM_BIT_SUP_SENS]    = supply.sens_under || supply.sens_over;
    next_warn[`VCM_BIT_SUP_ACT]     = supply.act_under || supply.act_over;
    next_warn[`VCM_BIT_PRESS_LOW]   = supply.press_low && suction_cmd;
    next_warn[`VCM_BIT_PRESS_RANGE] = supply.press_range;
    if (supply_bad && !supply_bad_prev) begin
      next_event_q = 1'b1;
    end

    // Undervoltage fallback
    if (under_v) begin
      next_manual = 1'b0;
      unique case (variant)
        VCM_VAR_OPEN:   next_valve = 1'b1;
        VCM_VAR_CLOSED: next_valve = 1'b0;
        default:        next_valve = valve;
      endcase
    end

    next_blink_ms = blink_ms;
    next_blink    = blink;
    if (ms_tick) begin
      if (blink_ms == 16'(BLINK_MS - 1)) begin
        next_blink_ms = 16'h0;
        next_blink    = !blink;
      end else begin
        next_blink_ms = blink_ms + 16'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state           <= ST_IDLE;
      warn            <= 9'h0;
      evac_first      <= 16'h0;
      evac_second     <= 16'h0;
      leak_rate       <= 16'h0;
      phase_ms        <= 16'h0;
      leak_start      <= 16'h0;
      lower_seen      <= 1'b0;
      upper_seen      <= 1'b0;
      saving_dis      <= 1'b0;
      valve           <= 1'b0;
      manual          <= 1'b0;
      suction_prev    <= 1'b0;
      supply_bad_prev <= 1'b0;
      event_q         <= 1'b0;
      evac_limit      <= `VCM_EVAC_LIMIT_RST;
      blink_ms        <= 16'h0;
      blink           <= 1'b0;
      rdata           <= 16'h0;
      ack             <= 1'b0;
    end else begin
      state           <= next_state;
      warn            <= next_warn;
      evac_first      <= next_evac_first;
      evac_second     <= next_evac_second;
      leak_rate       <= next_leak_rate;
      phase_ms        <= next_phase_ms;
      leak_start      <= next_leak_start;
      lower_seen      <= next_lower_seen;
      upper_seen      <= next_upper_seen;
      saving_dis      <= next_saving_dis;
      valve           <= next_valve;
      manual          <= next_manual;
      suction_prev    <= next_suction_prev;
      supply_bad_prev <= next_supply_bad_prev;
      event_q         <= next_event_q;
      evac_limit      <= next_evac_limit;
      blink_ms        <= next_blink_ms;
      blink           <= next_blink;
      rdata           <= next_rdata;
      ack             <= next_ack;
    end
  end

  // Drive is dropped at once on undervoltage, not a cycle later
  assign valve_drive_en  = !under_v;
  assign suction_valve   = valve;
  assign manual_active   = manual;
  assign air_saving_dis  = saving_dis;
  assign status_yellow   = (warn != 9'h0);
  assign show_leak_limit = warn[`VCM_BIT_LEAK] && blink;
  assign link_event      = event_q;
  assign param_rdata     = rdata;
  assign param_ack       = ack;
endmodule // vcm_condition_watch
`default_nettype wire

// >>> dv/vcm_link_master.sv
`timescale 1ns/100ps
`default_nettype none
module vcm_link_master (
  input  wire logic                      clk,
  output var  vcm_pkg::vcm_param_req_type param_req,
  input  wire logic               [15:0] param_rdata,
  input  wire logic                      param_ack
);
  import vcm_pkg::*;
  initial param_req = '0;
  // Request lasts one edge only: a longer hold would be taken twice
  task automatic access(input logic wr, input logic [15:0] idx, wd, output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    param_req <= '{1'b1, wr, idx, wd};
    @(posedge clk);
    param_req.req <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (param_ack !== 1'b1 && n < 8);
    rd = param_rdata;
  endtask
endmodule // vcm_link_master
`default_nettype wire

// >>> dv/vcm_condition_watch_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module vcm_condition_watch_checker #(
  parameter int MS_CYCLES = 10,
  parameter int LEAK_MS   = 5,
  parameter int DYN_MS    = 5,
  parameter int BLINK_MS  = 4
) (
  input wire logic                       clk,
  input wire logic                       reset_n,
  input wire vcm_pkg::vcm_param_req_type param_req,
  input wire logic                       param_ack,
  input wire logic                       suction_cmd,
  input wire vcm_pkg::vcm_supply_type    supply,
  input wire logic                       suction_valve,
  input wire logic                       valve_drive_en,
  input wire logic                       manual_active,
  input wire logic                       air_saving_dis,
  input wire logic                       status_yellow,
  input wire logic                       link_event
);
  import vcm_pkg::*;
  logic [3:0] flt_q;
  logic       under;
  logic       rise;
  assign under = supply.sens_under | supply.act_under;
  assign rise  = |(supply[5:2] & ~flt_q);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flt_q <= 4'h0;
    end else begin
      flt_q <= supply[5:2];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_req; param_req.req; endsequence
  sequence s_under2; supply.sens_under [*2]; endsequence
  sequence s_prot2; (air_saving_dis && suction_cmd) [*2]; endsequence
  property p_ack; s_req |=> param_ack; endproperty
  property p_ack_only; param_ack |-> $past(param_req.req); endproperty
  property p_evt; rise |=> link_event; endproperty
  property p_evt_cause; link_event |-> $past(rise); endproperty
  property p_drive; valve_drive_en == !under; endproperty
  property p_manual; under |=> !manual_active; endproperty
  property p_yellow; s_under2 |-> status_yellow; endproperty
  property p_prot; s_prot2 |-> suction_valve; endproperty
  property p_start; $rose(suction_cmd) |=> suction_valve; endproperty
  a_ack: assert property (p_ack) else $error("request without ack");
  a_ack_only: assert property (p_ack_only) else $error("ack without request");
  a_evt: assert property (p_evt) else $error("supply fault gave no event");
  a_evt_cause: assert property (p_evt_cause) else $error("event without fault");
  a_drive: assert property (p_drive) else $error("valve drive wrong on supply");
  a_manual: assert property (p_manual) else $error("manual kept in undervoltage");
  a_yellow: assert property (p_yellow) else $error("status not yellow on fault");
  a_prot: assert property (p_prot) else $error("protection left suction off");
  a_start: assert property (p_start) else $error("no suction at cycle start");
endmodule // vcm_condition_watch_checker
bind vcm_condition_watch vcm_condition_watch_checker #(
  .MS_CYCLES(MS_CYCLES), .LEAK_MS(LEAK_MS), .DYN_MS(DYN_MS), .BLINK_MS(BLINK_MS)
) chk_i (.clk, .reset_n, .param_req, .param_ack, .suction_cmd, .supply, .suction_valve,
  .valve_drive_en, .manual_active, .air_saving_dis, .status_yellow, .link_event);
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "vcm_map.svh"
module testbench;
  import vcm_pkg::*;
  localparam int MS = 10;
  logic clk, reset_n, param_ack, suction_cmd, air_saving_en, control_mode, manual_req;
  logic suction_valve, valve_drive_en, manual_active, air_saving_dis;
  logic status_yellow, show_leak_limit, link_event;
  logic              [15:0] param_rdata, vacuum, leak_rate, rd;
  vcm_param_req_type        param_req;
  vcm_variant_type          variant;
  vcm_limits_type           limits;
  vcm_supply_type           supply;
  int                       err_count = 0;
  int                       total_checks = 0;
  int                       cycles = 0;
  vcm_condition_watch #(.MS_CYCLES(MS), .LEAK_MS(5), .DYN_MS(5), .BLINK_MS(4)) uut (
    .clk, .reset_n, .param_req, .param_rdata, .param_ack, .suction_cmd, .air_saving_en,
    .control_mode, .manual_req, .variant, .vacuum, .limits, .supply, .suction_valve,
    .valve_drive_en, .manual_active, .air_saving_dis, .status_yellow, .show_leak_limit,
    .link_event, .leak_rate);
  vcm_link_master master (.clk, .param_req, .param_rdata, .param_ack);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask
  task automatic ms(input int n);
    repeat (n * MS) @(posedge clk);
  endtask
  task automatic rdw(input logic [15:0] idx);
    master.access(1'b0, idx, 16'h0000, rd);
  endtask
  task automatic wrw(input logic [15:0] idx, d);
    master.access(1'b1, idx, d, rd);
  endtask
  task automatic cyc(input logic on);
    @(posedge clk);
    suction_cmd <= on;
    repeat (2) @(posedge clk);
  endtask
  // Protection trip pins the valve on, so stop waiting then
  task automatic wait_valve(input logic v);
    int n;
    n = 0;
    while (suction_valve !== v && air_saving_dis !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic t_regs;
    rdw(`VCM_IDX_WARN);
    chk(rd, 16'h0000, "warn after reset");
    rdw(`VCM_IDX_EVAC_LIMIT);
    chk(rd, 16'h0000, "limit reset");
    wrw(`VCM_IDX_EVAC_LIMIT, 16'h03E7);
    wrw(`VCM_IDX_EVAC_LIMIT, 16'h03E8);
    rdw(`VCM_IDX_EVAC_LIMIT);
    chk(rd, 16'h03E7, "limit top kept");
    wrw(`VCM_IDX_WARN, 16'h01FF);
    rdw(`VCM_IDX_WARN);
    chk(rd, 16'h0000, "warn read only");
    rdw(16'h0050);
    chk(rd, 16'h0000, "unmapped read");
    wrw(`VCM_IDX_EVAC_LIMIT, 16'h0000);
    $display("regs test done");
  endtask
  task automatic t_leak;
    int n;
    logic p;
    n = 0;
    control_mode <= 1'b1;
    air_saving_en <= 1'b1;
    cyc(1'b1);
    chk({15'h0000, suction_valve}, 16'h0001, "valve at start");
    ms(2);
    vacuum <= 16'h0258;
    wait_valve(1'b0);
    chk({15'h0000, suction_valve}, 16'h0000, "saving stop");
    vacuum <= 16'h0244;
    ms(7);
    chk(leak_rate, 16'h0014, "leak rate");
    p = show_leak_limit;
    repeat (100) begin
      @(posedge clk);
      n += (show_leak_limit !== p);
      p = show_leak_limit;
    end
    chk({15'h0000, n > 1}, 16'h0001, "display alternates");
    rdw(`VCM_IDX_WARN);
    chk({15'h0000, rd[2]}, 16'h0001, "leak bit");
    vacuum <= 16'h01EA;
    wait_valve(1'b1);
    chk({15'h0000, suction_valve}, 16'h0001, "resume suction");
    cyc(1'b0);
    vacuum <= 16'h0000;
    $display("leak test done");
  endtask
  task automatic t_evac;
    control_mode <= 1'b0;
    air_saving_en <= 1'b0;
    wrw(`VCM_IDX_EVAC_LIMIT, 16'h0001);
    cyc(1'b1);
    ms(3);
    vacuum <= 16'h01C2;
    ms(20);
    vacuum <= 16'h028A;
    ms(1);
    rdw(`VCM_IDX_EVAC_FIRST);
    chk({15'h0000, rd >= 16'h0002 && rd <= 16'h0004}, 16'h0001, "first time");
    rdw(`VCM_IDX_EVAC_SECOND);
    chk({15'h0000, rd >= 16'h0013 && rd <= 16'h0015}, 16'h0001, "second time");
    rdw(`VCM_IDX_WARN);
    chk({15'h0000, rd[1]}, 16'h0001, "evac bit");
    chk({15'h0000, rd[4]}, 16'h0001, "dynamic bit");
    chk({15'h0000, status_yellow}, 16'h0001, "yellow");
    cyc(1'b0);
    vacuum <= 16'h0000;
    $display("evac test done");
  endtask
  task automatic t_upper;
    cyc(1'b1);
    rdw(`VCM_IDX_WARN);
    chk({12'h000, rd[3:0]}, 16'h0000, "cycle bits cleared");
    chk({15'h0000, rd[4]}, 16'h0001, "dynamic bit kept");
    rdw(`VCM_IDX_EVAC_SECOND);
    chk(rd, 16'h0000, "time cleared");
    rdw(`VCM_IDX_LEAK);
    chk(rd, 16'h0000, "leak cleared");
    ms(2);
    cyc(1'b0);
    rdw(`VCM_IDX_WARN);
    chk({12'h000, rd[3:0]}, 16'h0008, "upper missed");
    ms(3);
    rdw(`VCM_IDX_WARN);
    chk({15'h0000, rd[3]}, 16'h0001, "upper bit held");
    $display("upper test done");
  endtask
  task automatic t_supply;
    logic ev;
    manual_req <= 1'b1;
    repeat (3) @(posedge clk);
    chk({15'h0000, manual_active}, 16'h0001, "manual on");
    for (int i = 0; i < 4; i++) begin
      supply <= 6'h20 >> i;
      ev = 1'b0;
      repeat (3) begin
        @(posedge clk);
        ev |= link_event;
      end
      chk({15'h0000, ev}, 16'h0001, "supply event");
      rdw(`VCM_IDX_WARN);
      chk({12'h000, rd[8:5]}, (i < 2) ? 16'h0001 : 16'h0002, "supply bit");
      if (i == 0) begin
        chk({15'h0000, manual_active}, 16'h0000, "manual left");
        chk({15'h0000, valve_drive_en}, 16'h0000, "valves idle");
        rdw(`VCM_IDX_DEVSTAT);
        chk(rd, 16'h0001, "device status");
      end
      supply <= 6'h00;
      repeat (3) @(posedge clk);
    end
    cyc(1'b1);
    variant <= VCM_VAR_CLOSED;
    supply <= 6'h08;
    repeat (3) @(posedge clk);
    chk({15'h0000, suction_valve}, 16'h0000, "closed variant off");
    variant <= VCM_VAR_OPEN;
    supply <= 6'h03;
    repeat (3) @(posedge clk);
    rdw(`VCM_IDX_WARN);
    chk({14'h0000, rd[8:7]}, 16'h0003, "pressure bits");
    supply <= 6'h00;
    repeat (3) @(posedge clk);
    rdw(`VCM_IDX_WARN);
    chk({12'h000, rd[8:5]}, 16'h0000, "bits follow now");
    cyc(1'b0);
    manual_req <= 1'b0;
    $display("supply test done");
  endtask
  task automatic t_protect;
    air_saving_en <= 1'b1;
    control_mode <= 1'b1;
    cyc(1'b1);
    for (int i = 0; i < 8; i++) begin
      vacuum <= 16'h0258;
      wait_valve(1'b0);
      vacuum <= 16'h01EA;
      wait_valve(1'b1);
    end
    chk({15'h0000, air_saving_dis}, 16'h0001, "saving dropped");
    chk({15'h0000, suction_valve}, 16'h0001, "held suction");
    rdw(`VCM_IDX_WARN);
    chk({15'h0000, rd[0]}, 16'h0001, "protection bit");
    cyc(1'b0);
    $display("protect test done");
  endtask
  initial begin
    reset_n = 1'b0;
    suction_cmd = 1'b0;
    air_saving_en = 1'b0;
    control_mode = 1'b0;
    manual_req = 1'b0;
    variant = VCM_VAR_OPEN;
    vacuum = 16'h0000;
    limits = {16'h0258, 16'h0190, 16'h0032, 16'h01F4, 16'h000A};
    supply = 6'h00;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_leak();
    t_evac();
    t_upper();
    t_supply();
    t_protect();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
